// >>> self_program_pkg.sv
// constants, encodings and register map of the self-programming flash control
`default_nettype none
package self_program_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] CSR_OFFSET  = 8'h00;
  localparam logic [7:0] LOCK_OFFSET = 8'h04;
  localparam int         OFFSET_W    = 8;

  // control and status field positions
  localparam int IRQ_EN_BIT = 7;
  localparam int BUSY_BIT   = 6;
  localparam int SIGNATURE_ROW_READ_BIT  = 5;
  localparam int REEN_BIT   = 4;
  localparam int STORE_BIT  = 0;
  localparam int CMD_W      = 5;
  localparam int CTRL_W     = 6;

  // accepted command patterns in the lower five bits
  localparam logic [4:0] CMD_FILL  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;

  // instruction windows in clock cycles
  localparam logic [2:0] STORE_WINDOW_CYC = 3'h4;
  localparam logic [2:0] LOAD_WINDOW_CYC  = 3'h3;
  localparam logic [2:0] WIN_ONE          = 3'h1;
  localparam logic [2:0] WIN_ZERO         = 3'h0;

  // pointer layout: word select and page select
  localparam int PTR_W    = 16;
  localparam int BYTE_SEL = 0;
  localparam int WORD_LSB = 1;
  localparam int WORD_W   = 7;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_W   = 8;

  // section boundaries as page numbers
  localparam logic [7:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'hF0;
  localparam logic [7:0] BOOT_FIRST_PAGE = 8'hE0;

  // lock byte layout and default
  localparam logic [7:0] LOCK_DEFAULT = 8'hFF;
  localparam int MAIN_LO_BIT  = 0;
  localparam int MAIN_HI_BIT  = 1;
  localparam int APP_LO_BIT   = 2;
  localparam int APP_HI_BIT   = 3;
  localparam int BOOT_LO_BIT  = 4;
  localparam int BOOT_HI_BIT  = 5;
  localparam int BLOCK_LSB    = 2;
  localparam int BLOCK_MSB    = 5;

  // bus encodings
  localparam logic       HRESP_OKAY = 1'b0;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // sequencer states
  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_ARMED = 3'b010,
    OP_BUSY  = 3'b100
  } op_state_e;

endpackage
`default_nettype wire

// >>> lock_protect_decode.sv
// decode of the lock byte into protection and blocking signals
`default_nettype none
module lock_protect_decode
  import self_program_pkg::*;
(
  input  wire logic [7:0] lock_byte_i,
  input  wire logic       exec_in_boot_i,
  input  wire logic       vectors_in_boot_i,
  input  wire logic       target_in_boot_i,
  output logic            ext_prog_inhibit_o,
  output logic            ext_verify_inhibit_o,
  output logic            fuse_locked_o,
  output logic            boot_lock_locked_o,
  output logic            self_write_allowed_o,
  output logic            app_read_block_o,
  output logic            boot_read_block_o,
  output logic            irq_mask_o
);
  import self_program_pkg::*;

  logic app_wr_lock;
  logic app_rd_lock;
  logic boot_wr_lock;
  logic boot_rd_lock;

  // main lock: mode 2 stops programming, mode 3 also verification
  assign ext_prog_inhibit_o   = ~lock_byte_i[MAIN_LO_BIT];
  assign fuse_locked_o        = ~lock_byte_i[MAIN_LO_BIT];
  assign ext_verify_inhibit_o = ~lock_byte_i[MAIN_LO_BIT] & ~lock_byte_i[MAIN_HI_BIT];
  assign boot_lock_locked_o   = ~lock_byte_i[MAIN_LO_BIT] & ~lock_byte_i[MAIN_HI_BIT];

  // section pairs: low bit clear is mode 2 or 3, high bit clear is mode 3 or 4
  assign app_wr_lock  = ~lock_byte_i[APP_LO_BIT];
  assign app_rd_lock  = ~lock_byte_i[APP_HI_BIT];
  assign boot_wr_lock = ~lock_byte_i[BOOT_LO_BIT];
  assign boot_rd_lock = ~lock_byte_i[BOOT_HI_BIT];

  // self-programming write permission for the addressed section
  assign self_write_allowed_o = target_in_boot_i ? ~boot_wr_lock : ~app_wr_lock;

  // cross-section read blocking and interrupt masking
  assign app_read_block_o  = exec_in_boot_i & app_rd_lock;
  assign boot_read_block_o = ~exec_in_boot_i & boot_rd_lock;
  assign irq_mask_o = (vectors_in_boot_i & ~exec_in_boot_i & app_rd_lock)
                    | (~vectors_in_boot_i & exec_in_boot_i & boot_rd_lock);

endmodule
`default_nettype wire

// >>> self_program_flash_control.sv
// self-programming control and status, store/load windows and lock handling
// Contract
// - ready interrupt requested while enable, global flag set and store-enable clear
// - erase or write to read-while-write section sets busy, blocking that section
// - busy clears by read-enable command after the operation or on buffer fill
// - signature read: load within three cycles returns signature byte, store does nothing
// - read-enable command re-enables section; refused while erase or write runs
// - writing read-enable during buffer loading aborts load and drops buffered data
// - boot lock set store programs boot lock bits from register zero, self-clears
// - load within three cycles after boot lock set returns lock or fuse byte
// - page write store writes buffer to pointer page, self-clears at end or expiry
// - page erase store erases pointer page, self-clears at end or expiry
// - processor stalled through erase or write of a no-read-while-write page
// - store-enable alone: store puts registers one:zero into buffer word at pointer
// - store-enable opens four-cycle store window, clears on store or expiry
// - store-enable stays set during erase or write as busy indication
// - only listed command patterns in lower five bits take effect; any write with read-enable set still aborts buffer loading
// - lock byte: six bits, all default one, restored only by chip erase; reset also loads the default here
// - main lock mode 2 inhibits external programming and locks fuses
// - main lock mode 3 inhibits external programming, verification, locks boot bits; code only raises boot_lock_locked_o, lock stores still program them
// - application pair mode 2 or 3 blocks self-programming writes there
// - application pair modes 3 and 4 block boot reads, mask interrupts
// - boot pair mode 2 or 3 blocks self-programming writes to boot section
// - boot pair modes 3 and 4 block application reads, mask interrupts
`default_nettype none
module self_program_flash_control
  import self_program_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  // bus slave
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // processor side
  input  wire logic              store_instr_i,
  input  wire logic              load_instr_i,
  input  wire logic [PTR_W-1:0]  pointer_i,
  input  wire logic [7:0]        gp_reg_zero_i,
  input  wire logic [7:0]        gp_reg_one_i,
  input  wire logic              global_irq_en_i,
  input  wire logic              exec_in_boot_i,
  input  wire logic              vectors_in_boot_i,
  output logic                   ready_irq_o,
  output logic                   stall_cpu_o,
  output logic                   irq_mask_o,
  output logic [7:0]             load_data_o,
  output logic                   load_valid_o,
  // flash array side
  input  wire logic [7:0]        sig_byte_i,
  input  wire logic [7:0]        fuse_byte_i,
  input  wire logic              flash_op_done_i,
  input  wire logic              chip_erase_i,
  output logic                   buf_wr_o,
  output logic [WORD_W-1:0]      buf_word_o,
  output logic [15:0]            buf_data_o,
  output logic                   buf_clear_o,
  output logic                   op_start_o,
  output logic                   op_erase_o,
  output logic [PAGE_W-1:0]      op_page_o,
  // protection
  output logic                   rw_section_blocked_o,
  output logic                   app_read_block_o,
  output logic                   boot_read_block_o,
  output logic                   ext_prog_inhibit_o,
  output logic                   ext_verify_inhibit_o,
  output logic                   fuse_locked_o,
  output logic                   boot_lock_locked_o,
  output logic [7:0]             lock_byte_o
);
  import self_program_pkg::*;

  op_state_e           state_reg;
  op_state_e           state_next;
  logic [CTRL_W-1:0]   ctrl_reg;
  logic                irq_en_reg;
  logic                rw_busy_reg;
  logic [2:0]          win_cnt_reg;
  logic                op_rww_reg;
  logic                buf_loaded_reg;
  logic [7:0]          lock_reg;
  logic                dph_wr_reg;
  logic [OFFSET_W-1:0] dph_addr_reg;
  logic [31:0]         hrdata_reg;
  logic [7:0]          load_data_reg;
  logic                load_valid_reg;
  logic                buf_wr_reg;
  logic [WORD_W-1:0]   buf_word_reg;
  logic [15:0]         buf_data_reg;
  logic                buf_clear_reg;
  logic                op_start_reg;
  logic                op_erase_reg;
  logic [PAGE_W-1:0]   op_page_reg;

  logic                addr_take;
  logic                csr_wr;
  logic [7:0]          wr_byte;
  logic [CMD_W-1:0]    wr_cmd;
  logic                cmd_legal;
  logic                csr_cmd_accept;
  logic                op_busy;
  logic                store_take;
  logic                load_take;
  logic [CMD_W-1:0]    cmd;
  logic [PAGE_W-1:0]   tgt_page;
  logic                tgt_rww;
  logic                tgt_boot;
  logic                write_allowed;
  logic                op_launch;
  logic [7:0]          csr_value;
  logic [7:0]          rd_mux;

  // bus address phase and command decode
  assign addr_take      = hsel_i & htrans_i[1] & hready_i;
  assign csr_wr         = dph_wr_reg & (dph_addr_reg == CSR_OFFSET);
  assign wr_byte        = hwdata_i[7:0];
  assign wr_cmd         = wr_byte[CMD_W-1:0];
  assign op_busy        = (state_reg == OP_BUSY);
  assign cmd            = ctrl_reg[CMD_W-1:0];
  assign tgt_page       = pointer_i[PAGE_LSB +: PAGE_W];
  assign tgt_rww        = (tgt_page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
  assign tgt_boot       = (tgt_page >= BOOT_FIRST_PAGE);

  // only listed patterns arm a window; signature read rides on the fill code
  always_comb begin
    if (wr_byte[SIGNATURE_ROW_READ_BIT]) begin
      cmd_legal = (wr_cmd == CMD_FILL);
    end else begin
      cmd_legal = (wr_cmd == CMD_FILL) || (wr_cmd == CMD_ERASE) ||
                  (wr_cmd == CMD_WRITE) || (wr_cmd == CMD_LOCK) ||
                  (wr_cmd == CMD_REEN);
    end
  end

  // commands during a running erase or write are refused
  assign csr_cmd_accept = csr_wr & cmd_legal & ~op_busy;
  assign store_take     = store_instr_i & (state_reg == OP_ARMED) & ~csr_cmd_accept;
  assign load_take      = load_instr_i & (state_reg == OP_ARMED)
                        & (win_cnt_reg > (STORE_WINDOW_CYC - LOAD_WINDOW_CYC));
  assign op_launch      = store_take & ((cmd == CMD_ERASE) || (cmd == CMD_WRITE))
                        & ~ctrl_reg[SIGNATURE_ROW_READ_BIT] & write_allowed;

  // lock byte decode
  lock_protect_decode u_lock_decode (
    .lock_byte_i          (lock_reg),
    .exec_in_boot_i       (exec_in_boot_i),
    .vectors_in_boot_i    (vectors_in_boot_i),
    .target_in_boot_i     (tgt_boot),
    .ext_prog_inhibit_o   (ext_prog_inhibit_o),
    .ext_verify_inhibit_o (ext_verify_inhibit_o),
    .fuse_locked_o        (fuse_locked_o),
    .boot_lock_locked_o   (boot_lock_locked_o),
    .self_write_allowed_o (write_allowed),
    .app_read_block_o     (app_read_block_o),
    .boot_read_block_o    (boot_read_block_o),
    .irq_mask_o           (irq_mask_o)
  );

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      OP_IDLE: begin
        if (csr_cmd_accept) begin
          state_next = OP_ARMED;
        end
      end
      OP_ARMED: begin
        if (csr_cmd_accept) begin
          state_next = OP_ARMED;
        end else if (op_launch) begin
          state_next = OP_BUSY;
        end else if (store_take || (win_cnt_reg == WIN_ONE)) begin
          state_next = OP_IDLE;
        end
      end
      OP_BUSY: begin
        if (flash_op_done_i) begin
          state_next = OP_IDLE;
        end
      end
      default: state_next = OP_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= OP_IDLE;
    end else if (clk_en_i) begin
      state_reg <= state_next;
    end
  end

  // window counter restarts on each accepted write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      win_cnt_reg <= WIN_ZERO;
    end else if (clk_en_i) begin
      if (csr_cmd_accept) begin
        win_cnt_reg <= STORE_WINDOW_CYC;
      end else if ((state_reg == OP_ARMED) && (win_cnt_reg != WIN_ZERO)) begin
        win_cnt_reg <= 3'(win_cnt_reg - WIN_ONE);
      end else begin
        win_cnt_reg <= WIN_ZERO;
      end
    end
  end

  // command bits: armed by write, self-clear when the sequencer idles
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= '0;
    end else if (clk_en_i) begin
      if (csr_cmd_accept) begin
        ctrl_reg <= wr_byte[CTRL_W-1:0];
      end else if (state_next == OP_IDLE) begin
        ctrl_reg <= '0;
      end
    end
  end

  // interrupt enable is writable at any time
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_en_reg <= 1'b0;
    end else if (clk_en_i && csr_wr) begin
      irq_en_reg <= wr_byte[IRQ_EN_BIT];
    end
  end

  // section-busy flag
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rw_busy_reg <= 1'b0;
      op_rww_reg  <= 1'b0;
    end else if (clk_en_i) begin
      if (op_launch) begin
        op_rww_reg  <= tgt_rww;
        rw_busy_reg <= rw_busy_reg | tgt_rww;
      end else if (store_take && !ctrl_reg[SIGNATURE_ROW_READ_BIT] &&
                   ((cmd == CMD_REEN) || (cmd == CMD_FILL))) begin
        rw_busy_reg <= 1'b0;
      end
    end
  end

  // temporary buffer fill, abort and loaded tracking
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      buf_wr_reg     <= 1'b0;
      buf_word_reg   <= '0;
      buf_data_reg   <= '0;
      buf_clear_reg  <= 1'b0;
      buf_loaded_reg <= 1'b0;
    end else if (clk_en_i) begin
      buf_wr_reg    <= store_take & (cmd == CMD_FILL) & ~ctrl_reg[SIGNATURE_ROW_READ_BIT];
      buf_clear_reg <= csr_wr & wr_byte[REEN_BIT] & buf_loaded_reg;
      if (store_take && (cmd == CMD_FILL) && !ctrl_reg[SIGNATURE_ROW_READ_BIT]) begin
        buf_word_reg   <= pointer_i[WORD_LSB +: WORD_W];
        buf_data_reg   <= {gp_reg_one_i, gp_reg_zero_i};
        buf_loaded_reg <= 1'b1;
      end else if ((csr_wr && wr_byte[REEN_BIT]) || (op_launch && cmd == CMD_WRITE)) begin
        buf_loaded_reg <= 1'b0;
      end
    end
  end

  // erase or write launch toward the array
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      op_start_reg <= 1'b0;
      op_erase_reg <= 1'b0;
      op_page_reg  <= '0;
    end else if (clk_en_i) begin
      op_start_reg <= op_launch;
      if (op_launch) begin
        op_erase_reg <= (cmd == CMD_ERASE);
        op_page_reg  <= tgt_page;
      end
    end
  end

  // lock byte: bits only go to zero by store, back to one by chip erase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_reg <= LOCK_DEFAULT;
    end else if (clk_en_i) begin
      if (chip_erase_i) begin
        lock_reg <= LOCK_DEFAULT;
      end else if (store_take && (cmd == CMD_LOCK)) begin
        lock_reg[BLOCK_MSB:BLOCK_LSB] <= lock_reg[BLOCK_MSB:BLOCK_LSB]
                                       & gp_reg_zero_i[BLOCK_MSB:BLOCK_LSB];
      end
    end
  end

  // special loads: signature, lock or fuse byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      load_valid_reg <= 1'b0;
      load_data_reg  <= BYTE_ZERO;
    end else if (clk_en_i) begin
      load_valid_reg <= load_take & (ctrl_reg[SIGNATURE_ROW_READ_BIT] | (cmd == CMD_LOCK));
      if (load_take && ctrl_reg[SIGNATURE_ROW_READ_BIT]) begin
        load_data_reg <= sig_byte_i;
      end else if (load_take && (cmd == CMD_LOCK)) begin
        load_data_reg <= pointer_i[BYTE_SEL] ? lock_reg : fuse_byte_i;
      end
    end
  end

  // bus address phase capture and registered read data
  assign csr_value = {irq_en_reg, rw_busy_reg, ctrl_reg};
  always_comb begin
    rd_mux = BYTE_ZERO;
    if (haddr_i[OFFSET_W-1:0] == CSR_OFFSET) begin
      rd_mux = csr_value;
    end else if (haddr_i[OFFSET_W-1:0] == LOCK_OFFSET) begin
      rd_mux = lock_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dph_wr_reg   <= 1'b0;
      dph_addr_reg <= '0;
      hrdata_reg   <= '0;
    end else if (clk_en_i) begin
      dph_wr_reg <= addr_take & hwrite_i;
      if (addr_take) begin
        dph_addr_reg <= haddr_i[OFFSET_W-1:0];
        hrdata_reg   <= {24'h000000, rd_mux};
      end
    end
  end

  // outputs
  assign hrdata_o             = hrdata_reg;
  assign hreadyout_o          = 1'b1;
  assign hresp_o              = HRESP_OKAY;
  assign ready_irq_o          = irq_en_reg & global_irq_en_i & ~ctrl_reg[STORE_BIT];
  assign stall_cpu_o          = op_busy & ~op_rww_reg;
  assign rw_section_blocked_o = rw_busy_reg;
  assign load_data_o          = load_data_reg;
  assign load_valid_o         = load_valid_reg;
  assign buf_wr_o             = buf_wr_reg;
  assign buf_word_o           = buf_word_reg;
  assign buf_data_o           = buf_data_reg;
  assign buf_clear_o          = buf_clear_reg;
  assign op_start_o           = op_start_reg;
  assign op_erase_o           = op_erase_reg;
  assign op_page_o            = op_page_reg;
  assign lock_byte_o          = lock_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || !clk_en_i);

  sequence s_armed_idle;
    csr_cmd_accept ##1 (!store_instr_i && !csr_cmd_accept)[*4];
  endsequence

  sequence s_rww_launch;
    op_launch && tgt_rww;
  endsequence

  chk_irq_request: assert property (
    (irq_en_reg && global_irq_en_i && state_reg == OP_IDLE) |-> ready_irq_o)
    else $error("ready interrupt not requested");

  chk_busy_set: assert property (
    s_rww_launch |=> rw_busy_reg && rw_section_blocked_o)
    else $error("section busy not set on launch");

  chk_busy_fill_clear: assert property (
    buf_wr_o |-> !rw_busy_reg)
    else $error("section busy survived a buffer fill");

  chk_window_expire: assert property (
    s_armed_idle |=> !ctrl_reg[STORE_BIT] && (state_reg == OP_IDLE))
    else $error("store window did not expire after four cycles");

  chk_stall_no_read_while_write_section: assert property (
    (op_launch && !tgt_rww) |=> stall_cpu_o until_with (flash_op_done_i))
    else $error("processor not stalled during protected operation");

  chk_busy_hold: assert property (
    op_busy |-> ctrl_reg[STORE_BIT] && !ready_irq_o)
    else $error("store enable dropped during operation");

  chk_illegal_ignored: assert property (
    (csr_wr && !cmd_legal && state_reg == OP_IDLE) |=>
      (state_reg == OP_IDLE) && !ctrl_reg[STORE_BIT])
    else $error("illegal pattern armed a window");

  chk_lock_program: assert property (
    (store_take && cmd == CMD_LOCK && !chip_erase_i) |=>
      lock_reg[BLOCK_MSB:BLOCK_LSB] == ($past(lock_reg[BLOCK_MSB:BLOCK_LSB])
                                       & $past(gp_reg_zero_i[BLOCK_MSB:BLOCK_LSB])))
    else $error("boot lock bits not programmed from register zero");

  chk_sig_load: assert property (
    (load_take && ctrl_reg[SIGNATURE_ROW_READ_BIT]) |=> load_valid_o && load_data_o == $past(sig_byte_i))
    else $error("signature byte not returned");

  chk_reen_refused: assert property (
    (op_busy && rw_busy_reg && !flash_op_done_i) |=> rw_busy_reg)
    else $error("section re-enabled while operation runs");

endmodule
`default_nettype wire

// >>> cpu_flash_model.sv
// processor core and flash array model facing the self-programming control
`default_nettype none
module cpu_flash_model #(parameter int DONE_CYC = 20) (
  input  wire logic        clk_i,
  input  wire logic        op_start_i,
  output logic             store_o,
  output logic             load_o,
  output logic [15:0]      ptr_o,
  output logic [7:0]       r0_o,
  output logic [7:0]       r1_o,
  output logic             done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial {store_o, load_o, ptr_o, r0_o, r1_o} = '0;
  // one store instruction; pointer bit zero kept clear for stores
  task automatic store(input logic [15:0] p, input logic [7:0] a, input logic [7:0] b);
    store_o <= 1'b1;
    ptr_o <= {p[15:1], 1'b0};
    r0_o <= a;
    r1_o <= b;
    @(posedge clk_i);
    store_o <= 1'b0;
  endtask
  // one load instruction; bit zero selects the byte
  task automatic load(input logic [15:0] p);
    load_o <= 1'b1;
    ptr_o <= p;
    @(posedge clk_i);
    load_o <= 1'b0;
  endtask
  // array finishes a fixed time after each start
  always @(posedge clk_i) begin
    cnt <= op_start_i ? DONE_CYC : (cnt > 0 ? cnt - 1 : 0);
  end
  assign done_o = (cnt == 1);
endmodule
`default_nettype wire

// >>> test_self_program_flash_control.sv
// self-checking bench of the self-programming flash control
`default_nettype none
module test_self_program_flash_control;
  import self_program_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0, gie = 1, st, ld_i, done;
  logic en = 1, cer = 0, boot = 0, arb;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, q;
  logic [1:0] htrans_i = 0;
  logic [15:0] ptr, bdat;
  logic [7:0] r0, r1, page, ldat, lock;
  logic [6:0] bword;
  logic hrdy, irq, stall, lvalid, bwr, bclr, ostart, oerase;
  int fails = 0, comparisons = 0, nbuf = 0, nop = 0, nclr = 0;
  logic [7:0] ld = 0;
  cpu_flash_model cpu (.clk_i(clk_i), .op_start_i(ostart), .store_o(st), .load_o(ld_i),
    .ptr_o(ptr), .r0_o(r0), .r1_o(r1), .done_o(done));
  self_program_flash_control uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(en),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hrdy), .hrdata_o(hrdata_o),
    .hreadyout_o(hrdy), .hresp_o(), .store_instr_i(st), .load_instr_i(ld_i),
    .pointer_i(ptr), .gp_reg_zero_i(r0), .gp_reg_one_i(r1), .global_irq_en_i(gie),
    .exec_in_boot_i(boot), .vectors_in_boot_i(1'b0), .ready_irq_o(irq),
    .stall_cpu_o(stall), .irq_mask_o(), .load_data_o(ldat), .load_valid_o(lvalid),
    .sig_byte_i(8'h5A), .fuse_byte_i(8'hC3), .flash_op_done_i(done), .chip_erase_i(cer),
    .buf_wr_o(bwr), .buf_word_o(bword), .buf_data_o(bdat), .buf_clear_o(bclr),
    .op_start_o(ostart), .op_erase_o(oerase), .op_page_o(page), .rw_section_blocked_o(),
    .app_read_block_o(arb), .boot_read_block_o(), .ext_prog_inhibit_o(),
    .ext_verify_inhibit_o(), .fuse_locked_o(), .boot_lock_locked_o(), .lock_byte_o(lock));
  initial forever #25 clk_i = ~clk_i;
  // pulse counters and load capture
  always @(posedge clk_i) begin
    nbuf <= nbuf + int'(bwr);
    nop <= nop + int'(ostart);
    nclr <= nclr + int'(bclr);
    if (lvalid) ld <= ldat;
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // one single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge clk_i); while (hrdy !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("reg", {24'h0, e}, q);
  endtask
  task automatic step();
    repeat (2) @(posedge clk_i);
  endtask
  // poll until store-enable drops
  task automatic idle();
    do bus(1'b0, CSR_OFFSET, 8'h00); while (q[0] !== 1'b0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    wrap_up();
  end
  initial begin
    static logic [7:0] cmd[3] = '{8'h21, 8'h09, 8'h09};
    static logic [7:0] exp[3] = '{8'h5A, 8'hFF, 8'hC3};
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(CSR_OFFSET, 8'h00);
    rd(LOCK_OFFSET, 8'hFF);
    rd(8'h08, 8'h00);
    bus(1'b1, CSR_OFFSET, 8'h07);
    rd(CSR_OFFSET, 8'h00);
    bus(1'b1, CSR_OFFSET, 8'h01);
    cpu.store(16'h000B, 8'hCD, 8'hAB);
    step();
    chk("fill", {nbuf, 9'(bword), bdat}, {32'd1, 9'd5, 16'hABCD});
    rd(CSR_OFFSET, 8'h00);
    bus(1'b1, CSR_OFFSET, 8'h11);
    step();
    chk("drop", nclr, 1);
    bus(1'b1, CSR_OFFSET, 8'h01);
    repeat (5) @(posedge clk_i);
    cpu.store(16'h0002, 8'h11, 8'h22);
    step();
    chk("late", nbuf, 1);
    bus(1'b1, CSR_OFFSET, 8'h03);
    cpu.store(16'h1000, 8'h00, 8'h00);
    step();
    chk("erase", {nop, 1'(oerase), page}, {32'd1, 1'b1, 8'h10});
    rd(CSR_OFFSET, 8'h43);
    bus(1'b1, CSR_OFFSET, 8'h11);
    rd(CSR_OFFSET, 8'h43);
    idle();
    chk("done", q, 32'h40);
    bus(1'b1, CSR_OFFSET, 8'h11);
    cpu.store(16'h0000, 8'h00, 8'h00);
    rd(CSR_OFFSET, 8'h00);
    bus(1'b1, CSR_OFFSET, 8'h05);
    cpu.store(16'hF200, 8'h00, 8'h00);
    step();
    chk("no_read_while_write_section", {stall, oerase, page}, {1'b1, 1'b0, 8'hF2});
    idle();
    chk("free", stall, 1'b0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, CSR_OFFSET, cmd[i]);
      cpu.load(16'(i & 1));
      step();
      chk("load", ld, exp[i]);
    end
    bus(1'b1, CSR_OFFSET, 8'h09);
    cpu.store(16'h0000, 8'hF3, 8'h00);
    step();
    rd(LOCK_OFFSET, 8'hF3);
    boot <= 1'b1;
    step();
    chk("rdblk", {arb, lock}, {1'b1, 8'hF3});
    boot <= 1'b0;
    bus(1'b1, CSR_OFFSET, 8'h03);
    cpu.store(16'h1000, 8'h00, 8'h00);
    step();
    chk("blocked", nop, 2);
    cer <= 1'b1;
    @(posedge clk_i);
    cer <= 1'b0;
    rd(LOCK_OFFSET, 8'hFF);
    bus(1'b1, CSR_OFFSET, 8'h80);
    step();
    chk("irq", irq, 1'b1);
    bus(1'b1, CSR_OFFSET, 8'h81);
    step();
    chk("irq", irq, 1'b0);
    bus(1'b1, CSR_OFFSET, 8'h01);
    en <= 1'b0;
    repeat (8) @(posedge clk_i);
    en <= 1'b1;
    cpu.store(16'h0004, 8'h01, 8'h02);
    step();
    chk("freeze", {nbuf, 9'(bword)}, {32'd2, 9'd2});
    wrap_up();
  end
endmodule
`default_nettype wire
